// ### rtl/ptp_frame_timestamping.sv
`include "ptp_stamp_cfg.svh"
module ptp_frame_timestamping #(
    parameter int TAG_DEPTH = `PTP_TAG_DEPTH,
    parameter int INSERT_WORD = `PTP_INSERT_WORD
) (
    input logic clk_sys,
    input logic nrst,
    input logic tx_path_reset,
    input ptp_stamp_pkg::stamp_t tx_systimer,
    input ptp_stamp_pkg::stamp_t rx_systimer,
    input ptp_stamp_pkg::tx_beat_t tx_in,
    input ptp_stamp_pkg::op_t tx_stamp_operation,
    input ptp_stamp_pkg::tag_t tx_tag_in,
    output ptp_stamp_pkg::tx_beat_t tx_out,
    output logic tx_stamp_valid,
    output ptp_stamp_pkg::stamp_rec_t tx_stamp_rec,
    output logic tx_fifo_write_error,
    output logic tx_fifo_read_error,
    input ptp_stamp_pkg::segs_t rx_sop_in,
    output ptp_stamp_pkg::segs_t rx_sop_out,
    output logic rx_stamp_valid,
    output ptp_stamp_pkg::stamp_t rx_stamp
);
    import ptp_stamp_pkg::*;

    core_st_t st_q, st_d;
    logic sop_v, eop_v, in_frame;
    logic one_now, stamped_now;
    logic [`PTP_WORD_W-1:0] word_now;
    stamp_t ins_stamp;
    tx_beat_t beat;
    logic push, fifo_empty;
    stamp_rec_t push_rec, head_rec;

    ////////////////////////////////////////////////////////////////////////////////
    // stamp store between frame start and frame end

    assign push_rec = '{tag: tx_tag_in, stamp: tx_systimer};

    ptp_tag_fifo #(
        .DEPTH(TAG_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clear(tx_path_reset),
        .push(push),
        .push_rec(push_rec),
        .pop(st_q.pend),
        .head_rec(head_rec),
        .empty(fifo_empty),
        .full(),
        .wr_err(tx_fifo_write_error),
        .rd_err(tx_fifo_read_error)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // transmit path

    // the capture plane is this block's input: the stamp is the timer in the sop beat
    assign sop_v = tx_in.valid && tx_in.sop;
    assign eop_v = tx_in.valid && tx_in.eop;
    assign in_frame = sop_v || (st_q.state == TX_FRAME);
    // a sop beat decides for itself, later beats follow what the sop decided
    assign one_now = sop_v ? (tx_stamp_operation == `PTP_OP_ONE_STEP) : st_q.one_step;
    assign stamped_now = sop_v ? op_stamps(tx_stamp_operation) : st_q.stamped;
    assign word_now = sop_v ? '0 : st_q.word;
    assign ins_stamp = sop_v ? tx_systimer : st_q.cap;

    always_comb begin
        st_d = st_q;
        beat = tx_in;
        push = 1'b0;
        st_d.pend = 1'b0;
        st_d.valid = 1'b0;
        if (sop_v) begin
            st_d.cap = tx_systimer;
            st_d.one_step = one_now;
            st_d.stamped = stamped_now;
            // tag is only looked at when the frame takes a stamp
            push = stamped_now;
        end
        // frame tracking; a sop inside a frame restarts it, and any eop ends it, so a
        // one-beat frame inside an open frame leaves no frame behind to count stray beats
        case (st_q.state)
            TX_IDLE: begin
                if (sop_v && !eop_v) begin
                    st_d.state = TX_FRAME;
                end
            end
            TX_FRAME: begin
                if (eop_v) begin
                    st_d.state = TX_IDLE;
                end
            end
            default: begin
                st_d.state = TX_IDLE;
            end
        endcase
        if (tx_in.valid && in_frame) begin
            // counter saturates so very long frames never reinsert
            if (word_now != '1) begin
                st_d.word = `PTP_WORD_W'(word_now + 1'b1);
            end else begin
                st_d.word = word_now;
            end
            // single-step frames that reach beat INSERT_WORD get the stamp written into that beat
            if (one_now && (word_now == `PTP_WORD_W'(INSERT_WORD))) begin
                beat.data[`PTP_TIMER_W-1:0] = ins_stamp;
            end
            // report at frame end; the pop waits a cycle so a one-beat frame
            // finds its own entry already stored
            st_d.pend = eop_v && stamped_now;
        end
        st_d.out = beat;
        // the fetched entry is presented for exactly one cycle
        st_d.valid = st_q.pend && !fifo_empty;
        if (st_q.pend && !fifo_empty) begin
            st_d.rec = head_rec;
        end
        if (tx_path_reset) begin
            st_d.state = TX_IDLE;
            st_d.one_step = 1'b0;
            st_d.stamped = 1'b0;
            st_d.word = '0;
            st_d.pend = 1'b0;
            st_d.valid = 1'b0;
            st_d.out = '0;
            push = 1'b0;
        end
        // receive: stamp and sop move through one register together, so the
        // stamp shows in the cycle the sop leaves; timer taken as is
        st_d.rx_sop = rx_sop_in;
        if (|rx_sop_in) begin
            st_d.rx_stamp = rx_systimer;
        end
    end

    // timers are same-clock inputs and are not resynchronised
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign tx_out = st_q.out;
    assign tx_stamp_valid = st_q.valid;
    assign tx_stamp_rec = st_q.rec;
    assign rx_sop_out = st_q.rx_sop;
    assign rx_stamp_valid = |st_q.rx_sop;
    assign rx_stamp = st_q.rx_stamp;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence noop_sop_s;
        sop_v && !op_stamps(tx_stamp_operation) && !tx_path_reset;
    endsequence

    sequence lone_stamp_s;
        sop_v && tx_in.eop && op_stamps(tx_stamp_operation) && fifo_empty && !tx_path_reset;
    endsequence

    sequence quiet_s;
        !tx_path_reset && !tx_in.valid;
    endsequence

    noop_no_push_a: assert property (noop_sop_s |-> !push)
        else $error("tag stored for a frame without stamp");

    noop_untouched_a: assert property (noop_sop_s |=> tx_out.data == $past(tx_in.data))
        else $error("no-operation frame was modified");

    rsvd_as_noop_a: assert property (
        sop_v && (tx_stamp_operation == `PTP_OP_RSVD) && !tx_path_reset
        |-> !push ##1 (tx_out.data == $past(tx_in.data)))
        else $error("reserved operation did not act as no operation");

    two_step_untouched_a: assert property (
        tx_in.valid && !tx_path_reset && !one_now
        |=> tx_out.data == $past(tx_in.data))
        else $error("two-step frame was modified");

    one_step_insert_a: assert property (
        tx_in.valid && in_frame && one_now && !tx_path_reset
        && (word_now == `PTP_WORD_W'(INSERT_WORD))
        |=> tx_out.data[`PTP_TIMER_W-1:0] == $past(ins_stamp)
        && tx_out.data[`PTP_DATA_W-1:`PTP_TIMER_W]
        == $past(tx_in.data[`PTP_DATA_W-1:`PTP_TIMER_W]))
        else $error("single-step stamp not inserted");

    capture_time_a: assert property (
        sop_v && !tx_path_reset |=> st_q.cap == $past(tx_systimer))
        else $error("transmit stamp not taken at frame start");

    tag_echo_a: assert property (
        lone_stamp_s ##1 !tx_path_reset |=> tx_stamp_valid
        && tx_stamp_rec.tag == $past(tx_tag_in, 2)
        && tx_stamp_rec.stamp == $past(tx_systimer, 2))
        else $error("tag or stamp returned wrongly");

    valid_pulse_a: assert property (
        lone_stamp_s ##1 quiet_s |-> ##1 tx_stamp_valid ##1 !tx_stamp_valid)
        else $error("stamp valid not a single pulse");

    valid_cause_a: assert property (
        tx_stamp_valid |-> $past(st_q.pend) && !$past(fifo_empty))
        else $error("stamp valid without a fetched entry");

    rx_same_cycle_a: assert property (
        |rx_sop_in |=> rx_stamp_valid && rx_sop_out == $past(rx_sop_in)
        && rx_stamp == $past(rx_systimer))
        else $error("receive stamp not aligned with sop");

    wr_err_hold_a: assert property (
        tx_fifo_write_error && !tx_path_reset |=> tx_fifo_write_error)
        else $error("write error flag dropped without reset");

    rd_err_hold_a: assert property (
        tx_fifo_read_error && !tx_path_reset |=> tx_fifo_read_error)
        else $error("read error flag dropped without reset");
endmodule

// ### rtl/ptp_stamp_cfg.svh
`ifndef PTP_STAMP_CFG_SVH
`define PTP_STAMP_CFG_SVH
// How it works
// - Operation 2'h0 takes no timestamp and leaves the outgoing frame untouched.
// - Operation 2'h2 takes a timestamp, reports it on the stamp outputs, and leaves the frame.
// - Operation 2'h3 is treated exactly like operation 2'h0.
// - The 16-bit tag input is ignored for frames that take no timestamp.
// - A stamped frame returns its own 16-bit tag and timestamp, unless it is restarted by a new start; its entry then goes out for the next frame.
// - The transmit stamp valid output is high for one cycle per reported stamp; the stamp outputs hold until the next one.
// - The transmit stamp is the transmit timer value when the frame start was taken.
// - The receive stamp is the receive timer value when the frame start was taken.
// - A failed tag store into the stamp fifo sets a write error flag held until tx path reset.
// - A failed tag fetch from the stamp fifo sets a read error flag held until tx path reset.

// widths
`define PTP_TIMER_W 80
`define PTP_TAG_W 16
`define PTP_OP_W 2
`define PTP_DATA_W 128
`define PTP_RX_SEGS 4
`define PTP_WORD_W 8
// operation codes
`define PTP_OP_NONE 2'h0
`define PTP_OP_ONE_STEP 2'h1
`define PTP_OP_TWO_STEP 2'h2
`define PTP_OP_RSVD 2'h3
// timer layouts, normal and transparent clock
`define PTP_SEC_LSB 32
`define PTP_TC_ZERO_BIT 63
`define PTP_TC_NS_LSB 16
// structure defaults
`define PTP_TAG_DEPTH 4
`define PTP_INSERT_WORD 1
`endif

// ### rtl/ptp_stamp_pkg.sv
`include "ptp_stamp_cfg.svh"
package ptp_stamp_pkg;
    typedef logic [`PTP_TIMER_W-1:0] stamp_t;
    typedef logic [`PTP_TAG_W-1:0] tag_t;
    typedef logic [`PTP_OP_W-1:0] op_t;
    typedef logic [`PTP_RX_SEGS-1:0] segs_t;

    // one reported stamp with the tag that goes back with it
    typedef struct packed {
        tag_t tag;
        stamp_t stamp;
    } stamp_rec_t;

    // one beat of the transmit stream
    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic [`PTP_DATA_W-1:0] data;
    } tx_beat_t;

    typedef enum logic [0:0] {TX_IDLE, TX_FRAME} tx_state_t;

    // whole state of the timestamping core
    typedef struct packed {
        tx_state_t state;
        logic one_step;
        logic stamped;
        logic [`PTP_WORD_W-1:0] word;
        stamp_t cap;
        tx_beat_t out;
        logic pend;
        logic valid;
        stamp_rec_t rec;
        segs_t rx_sop;
        stamp_t rx_stamp;
    } core_st_t;

    // true for the two codes that take a timestamp
    function automatic logic op_stamps(input op_t op);
        return (op == `PTP_OP_ONE_STEP) || (op == `PTP_OP_TWO_STEP);
    endfunction
endpackage

// ### rtl/ptp_tag_fifo.sv
`include "ptp_stamp_cfg.svh"
module ptp_tag_fifo #(
    parameter int DEPTH = `PTP_TAG_DEPTH
) (
    input logic clk_sys,
    input logic nrst,
    input logic clear,
    input logic push,
    input ptp_stamp_pkg::stamp_rec_t push_rec,
    input logic pop,
    output ptp_stamp_pkg::stamp_rec_t head_rec,
    output logic empty,
    output logic full,
    output logic wr_err,
    output logic rd_err
);
    import ptp_stamp_pkg::*;
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int RW = $bits(stamp_rec_t);

    typedef struct packed {
        logic [DEPTH-1:0][RW-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic wr_err;
        logic rd_err;
    } fifo_st_t;

    fifo_st_t st_q, st_d;
    logic do_push, do_pop;

    // pointer step with wrap, depth need not be a power of two
    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign empty = (st_q.cnt == '0);
    assign full = (st_q.cnt == (AW + 1)'(DEPTH));
    assign head_rec = stamp_rec_t'(st_q.mem[st_q.rp]);
    assign wr_err = st_q.wr_err;
    assign rd_err = st_q.rd_err;

    // a pop in the same cycle frees room, so a full fifo still takes the push
    always_comb begin
        st_d = st_q;
        do_pop = pop && !empty;
        do_push = push && (!full || do_pop);
        if (do_push) begin
            st_d.mem[st_q.wp] = RW'(push_rec);
            st_d.wp = nxt(st_q.wp);
        end
        if (do_pop) begin
            st_d.rp = nxt(st_q.rp);
        end
        st_d.cnt = (AW + 1)'(st_q.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop));
        if (clear) begin
            st_d.wp = '0;
            st_d.rp = '0;
            st_d.cnt = '0;
        end
        // a new error in the clearing cycle still sets the flag
        st_d.wr_err = (st_q.wr_err && !clear) || (push && !do_push);
        st_d.rd_err = (st_q.rd_err && !clear) || (pop && empty);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ### tb/ptp_timer_src.sv
module ptp_timer_src (
    input logic clk_sys,
    input logic nrst,
    output ptp_stamp_pkg::stamp_t tx_systimer,
    output ptp_stamp_pkg::stamp_t rx_systimer
);
    timeunit 1ns;
    timeprecision 1ps;
    import ptp_stamp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic [47:0] sec_q;
    logic [31:0] ns_q;
    logic [46:0] tc_ns_q;
    logic [15:0] frac_q;

    // both timers tick on the block clock; ns starts near a wrap so the carry is exercised
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sec_q <= 48'h0000_0000_0001;
            ns_q <= 32'h3b9a_c990;
            tc_ns_q <= 47'h0000_0000_7ff0;
            frac_q <= 16'h0000;
        end else begin
            sec_q <= (ns_q >= 32'h3b9a_c9f6) ? sec_q + 48'h1 : sec_q;
            ns_q <= (ns_q >= 32'h3b9a_c9f6) ? ns_q - 32'h3b9a_c9f6 : ns_q + 32'ha;
            tc_ns_q <= tc_ns_q + 47'ha;
            frac_q <= frac_q + 16'h1d3b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // normal format on transmit, transparent format on receive
    assign tx_systimer = {sec_q, ns_q};
    assign rx_systimer = {16'h0000, 1'b0, tc_ns_q, frac_q};
endmodule

// ### tb/test_ptp_frame_timestamping.sv
`include "ptp_stamp_cfg.svh"
module test_ptp_frame_timestamping;
    timeunit 1ns;
    timeprecision 1ps;
    import ptp_stamp_pkg::*;

    localparam int INS = 1;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic tx_path_reset = 1'b0;
    stamp_t tx_systimer, rx_systimer, rx_stamp;
    stamp_t exp_st = '0;
    tx_beat_t tx_in = '0;
    tx_beat_t tx_out;
    op_t tx_stamp_operation = '0;
    tag_t tx_tag_in = '0;
    logic tx_stamp_valid, tx_fifo_write_error, tx_fifo_read_error, rx_stamp_valid;
    stamp_rec_t tx_stamp_rec;
    stamp_rec_t last_rec = '0;
    segs_t rx_sop_in = '0;
    segs_t rx_sop_out, s;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 23;

    ////////////////////////////////////////////////////////////////////////////////
    always #5 clk_sys = ~clk_sys;

    // small tag store so that overflow is reached in three frames
    ptp_frame_timestamping #(.TAG_DEPTH(2), .INSERT_WORD(INS)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .tx_path_reset(tx_path_reset),
        .tx_systimer(tx_systimer), .rx_systimer(rx_systimer), .tx_in(tx_in),
        .tx_stamp_operation(tx_stamp_operation), .tx_tag_in(tx_tag_in), .tx_out(tx_out),
        .tx_stamp_valid(tx_stamp_valid), .tx_stamp_rec(tx_stamp_rec),
        .tx_fifo_write_error(tx_fifo_write_error), .tx_fifo_read_error(tx_fifo_read_error),
        .rx_sop_in(rx_sop_in), .rx_sop_out(rx_sop_out), .rx_stamp_valid(rx_stamp_valid),
        .rx_stamp(rx_stamp)
    );

    ptp_timer_src timers (
        .clk_sys(clk_sys), .nrst(nrst), .tx_systimer(tx_systimer), .rx_systimer(rx_systimer)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [131:0] seen, input logic [131:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // inputs always move 1 ns after the edge, clear of the sampling point
    task step;
        @(posedge clk_sys);
        #1;
    endtask

    function automatic logic [127:0] rnd128();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    function automatic logic takes(input op_t op);
        return op == `PTP_OP_ONE_STEP || op == `PTP_OP_TWO_STEP;
    endfunction

    // one frame of nb beats; op and tag noise on later beats must be ignored
    task automatic send(input op_t op, input int nb);
        tx_beat_t b;
        tx_beat_t e;
        tag_t tag;
        stamp_t tim;
        for (int i = 0; i < nb; i++) begin
            b = {1'b1, i == 0, i == nb - 1, rnd128()};
            tx_in = b;
            tx_tag_in = tag_t'($random(seed));
            tx_stamp_operation = (i == 0) ? op : op_t'($random(seed));
            if (i == 0) begin
                tag = tx_tag_in;
                tim = tx_systimer;
            end
            e = b;
            if (op == `PTP_OP_ONE_STEP && i == INS) begin
                e.data[79:0] = tim;
            end
            step;
            check(tx_out, e);
        end
        tx_in = '0;
        step;
        if (takes(op)) begin
            last_rec = {tag, tim};
        end
        check(tx_stamp_valid, takes(op));
        check(tx_stamp_rec, last_rec);
        step;
        check(tx_stamp_valid, 1'b0);
        check(tx_stamp_rec, last_rec);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #50000;
        fail_count++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        step;
        // every operation code, short and long frames
        for (int op = 0; op < 4; op++) begin
            send(op_t'(op), 2);
            send(op_t'(op), 1);
        end
        send(`PTP_OP_ONE_STEP, 3);
        repeat (30) send(op_t'($random(seed)), 1 + ($unsigned($random(seed)) % 3));
        // a one-beat frame inside an open frame must end it: a later stray beat is untouched
        tx_in = {3'b110, rnd128()};
        tx_stamp_operation = `PTP_OP_NONE;
        step;
        send(`PTP_OP_ONE_STEP, 1);
        tx_in = {3'b100, rnd128()};
        step;
        check(tx_out, tx_in);
        tx_in = '0;
        step;
        // receive side: sparse sop patterns, stamp must hold between them
        for (int i = 0; i < 40; i++) begin
            s = segs_t'($random(seed)) & segs_t'($random(seed));
            rx_sop_in = s;
            if (|s) begin
                exp_st = rx_systimer;
            end
            step;
            check(rx_sop_out, s);
            check(rx_stamp_valid, |s);
            check(rx_stamp, exp_st);
        end
        rx_sop_in = '0;
        // three stamped starts into a two-deep tag store: the third overflows
        for (int i = 0; i < 3; i++) begin
            tx_in = {3'b110, rnd128()};
            tx_stamp_operation = `PTP_OP_TWO_STEP;
            step;
            check(tx_fifo_write_error, i == 2);
        end
        tx_in = {3'b101, rnd128()};
        step;
        tx_in = '0;
        repeat (3) step;
        check(tx_fifo_write_error, 1'b1);
        check(tx_fifo_read_error, 1'b0);
        tx_path_reset = 1'b1;
        step;
        tx_path_reset = 1'b0;
        check(tx_fifo_write_error, 1'b0);
        check(tx_stamp_valid, 1'b0);
        close_out();
    end
endmodule
